// file: shared/interval_timer_pkg.sv
package interval_timer_pkg;

    // register indices on the plain register port
    localparam logic [2:0] ADDR_CONTROL    = 3'h0;
    localparam logic [2:0] ADDR_COUNT      = 3'h1;
    localparam logic [2:0] ADDR_PERIOD     = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MASK   = 3'h4;

    // control register field positions
    localparam int BIT_TIMER_ON      = 15;
    localparam int BIT_IDLE_STOP     = 13;
    localparam int BIT_WRITE_BLOCK   = 12;
    localparam int BIT_COUNT_PEND    = 11;
    localparam int BIT_PERIOD_PEND   = 10;
    localparam int BIT_EXT_SEL_HI    = 9;
    localparam int BIT_EXT_SEL_LO    = 8;
    localparam int BIT_GATED         = 7;
    localparam int BIT_PRESCALE_HI   = 5;
    localparam int BIT_PRESCALE_LO   = 4;
    localparam int BIT_INPUT_SYNC    = 2;
    localparam int BIT_CLOCK_SOURCE  = 1;

    // interrupt status / mask bit
    localparam int BIT_IRQ_PERIOD    = 0;

    // reset values
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hFFFF;

    // prescale select codes and ratios
    localparam logic [1:0] PRESCALE_1   = 2'h0;
    localparam logic [1:0] PRESCALE_8   = 2'h1;
    localparam logic [1:0] PRESCALE_64  = 2'h2;
    localparam logic [1:0] PRESCALE_256 = 2'h3;
    localparam logic [8:0] RATIO_1      = 9'h001;
    localparam logic [8:0] RATIO_8      = 9'h008;
    localparam logic [8:0] RATIO_64     = 9'h040;
    localparam logic [8:0] RATIO_256    = 9'h100;

    // extended clock select codes
    localparam logic [1:0] EXT_PIN       = 2'h0;
    localparam logic [1:0] EXT_INSTR     = 2'h1;
    localparam logic [1:0] EXT_OSC       = 2'h2;
    localparam logic [1:0] EXT_FAST_RC   = 2'h3;

    // cycles a posted write spends crossing into the counting domain
    localparam logic [1:0] POST_WRITE_CYCLES = 2'h3;

    typedef struct packed {
        logic       timerOn;
        logic       idleStop;
        logic       asyncWriteBlock;
        logic [1:0] extendedClockSelect;
        logic       gatedAccumulate;
        logic [1:0] prescaleSelect;
        logic       externalInputSync;
        logic       clockSourceSelect;
    } ctrl_type;

    typedef enum {
        MODE_TIMER,
        MODE_GATED,
        MODE_SYNC_COUNTER,
        MODE_ASYNC_COUNTER
    } mode_type;

endpackage

// file: src/timer_prescaler.sv
`timescale 1ns/1ps
module timer_prescaler (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       clear,
    input  wire logic [1:0] prescaleSelect,
    // ticks
    input  wire logic       tickIn,
    output logic            tickOut
);

    logic [8:0] ratio;
    logic [8:0] cnt_q;
    logic [8:0] cnt_d;

    always_comb begin
        unique case (prescaleSelect)
            interval_timer_pkg::PRESCALE_1:   ratio = interval_timer_pkg::RATIO_1;
            interval_timer_pkg::PRESCALE_8:   ratio = interval_timer_pkg::RATIO_8;
            interval_timer_pkg::PRESCALE_64:  ratio = interval_timer_pkg::RATIO_64;
            interval_timer_pkg::PRESCALE_256: ratio = interval_timer_pkg::RATIO_256;
        endcase
    end

    assign tickOut = tickIn && (cnt_q == ratio - 9'h001);

    always_comb begin
        cnt_d = cnt_q;
        if (clear) begin
            cnt_d = 9'h000;
        end else if (tickOut) begin
            cnt_d = 9'h000;
        end else if (tickIn) begin
            cnt_d = cnt_q + 9'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= 9'h000;
        end else begin
            cnt_q <= cnt_d;
        end
    end

endmodule

// file: src/interval_timer.sv
`timescale 1ns/1ps
module interval_timer (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    output logic      [15:0] regRdata,
    // clock sources, sampled as levels
    input  wire logic        externalCountInput,
    input  wire logic        instrClockIn,
    input  wire logic        oscClockIn,
    input  wire logic        fastRcClockIn,
    input  wire logic        gateIn,
    // power state
    input  wire logic        idleMode,
    input  wire logic        sleepMode,
    // events
    output logic             periodEvent,
    output logic             irq
);

    interval_timer_pkg::ctrl_type ctrl_q;
    interval_timer_pkg::ctrl_type ctrl_d;
    interval_timer_pkg::mode_type mode;

    logic [15:0] count_q;
    logic [15:0] count_d;
    logic [15:0] period_q;
    logic [15:0] period_d;
    logic [15:0] postCount_q;
    logic [15:0] postCount_d;
    logic [15:0] postPeriod_q;
    logic [15:0] postPeriod_d;
    logic        countPend_q;
    logic        countPend_d;
    logic        periodPend_q;
    logic        periodPend_d;
    logic [1:0]  countWait_q;
    logic [1:0]  countWait_d;
    logic [1:0]  periodWait_q;
    logic [1:0]  periodWait_d;
    logic        irqStatus_q;
    logic        irqStatus_d;
    logic        irqMask_q;
    logic        irqMask_d;
    logic [15:0] rdata_q;
    logic [15:0] rdata_d;
    logic        event_q;
    logic        event_d;
    logic        irqOut_q;
    logic        irqOut_d;

    logic        srcLevel;
    logic        srcPrev_q;
    logic        rawTick;
    logic        preTick;
    logic        syncA_q;
    logic        syncB_q;
    logic        countTick;
    logic        running;
    logic        match;
    logic        asyncMode;
    logic        syncCounter;
    logic        countWrite;
    logic        periodWrite;
    logic        countApply;
    logic        periodApply;

    function automatic interval_timer_pkg::mode_type decodeMode(
        input interval_timer_pkg::ctrl_type c
    );
        interval_timer_pkg::mode_type m;
        m = interval_timer_pkg::MODE_TIMER;
        if (c.clockSourceSelect) begin
            m = c.externalInputSync ? interval_timer_pkg::MODE_SYNC_COUNTER
                                    : interval_timer_pkg::MODE_ASYNC_COUNTER;
        end else if (c.gatedAccumulate) begin
            m = interval_timer_pkg::MODE_GATED;
        end
        return m;
    endfunction

    function automatic logic [15:0] packControl(
        input interval_timer_pkg::ctrl_type c,
        input logic cPend,
        input logic pPend
    );
        logic [15:0] v;
        v = 16'h0000;
        v[interval_timer_pkg::BIT_TIMER_ON]     = c.timerOn;
        v[interval_timer_pkg::BIT_IDLE_STOP]    = c.idleStop;
        v[interval_timer_pkg::BIT_WRITE_BLOCK]  = c.asyncWriteBlock;
        v[interval_timer_pkg::BIT_COUNT_PEND]   = cPend;
        v[interval_timer_pkg::BIT_PERIOD_PEND]  = pPend;
        v[interval_timer_pkg::BIT_EXT_SEL_HI:interval_timer_pkg::BIT_EXT_SEL_LO] =
            c.extendedClockSelect;
        v[interval_timer_pkg::BIT_GATED]        = c.gatedAccumulate;
        v[interval_timer_pkg::BIT_PRESCALE_HI:interval_timer_pkg::BIT_PRESCALE_LO] =
            c.prescaleSelect;
        v[interval_timer_pkg::BIT_INPUT_SYNC]   = c.externalInputSync;
        v[interval_timer_pkg::BIT_CLOCK_SOURCE] = c.clockSourceSelect;
        return v;
    endfunction

    assign mode        = decodeMode(ctrl_q);
    assign asyncMode   = (mode == interval_timer_pkg::MODE_ASYNC_COUNTER);
    assign syncCounter = (mode == interval_timer_pkg::MODE_SYNC_COUNTER);

    // clock source selection
    always_comb begin
        unique case (ctrl_q.extendedClockSelect)
            interval_timer_pkg::EXT_PIN:     srcLevel = externalCountInput;
            interval_timer_pkg::EXT_INSTR:   srcLevel = instrClockIn;
            interval_timer_pkg::EXT_OSC:     srcLevel = oscClockIn;
            interval_timer_pkg::EXT_FAST_RC: srcLevel = fastRcClockIn;
        endcase
        if (ctrl_q.clockSourceSelect) begin
            rawTick = srcLevel && !srcPrev_q;
        end else begin
            rawTick = 1'b1;
        end
    end

    // peripheral clock and synchronised counting stop in Sleep
    always_comb begin
        running = ctrl_q.timerOn;
        if (ctrl_q.idleStop && idleMode) begin
            running = 1'b0;
        end
        if (sleepMode && !asyncMode) begin
            running = 1'b0;
        end
        if (mode == interval_timer_pkg::MODE_GATED && !gateIn) begin
            running = 1'b0;
        end
    end

    timer_prescaler u_prescaler (
        .clk            (clk),
        .rst_n          (rst_n),
        .clear          (!ctrl_q.timerOn),
        .prescaleSelect (ctrl_q.prescaleSelect),
        .tickIn         (rawTick && running),
        .tickOut        (preTick)
    );

    // synchroniser sits behind the prescaler; unsynchronised path bypasses it
    always_comb begin
        if (syncCounter) begin
            countTick = syncB_q && running;
        end else begin
            countTick = preTick;
        end
    end

    assign match = (count_q == period_q);

    // posted write bookkeeping
    always_comb begin
        countWrite  = regWrite && (regAddr == interval_timer_pkg::ADDR_COUNT);
        periodWrite = regWrite && (regAddr == interval_timer_pkg::ADDR_PERIOD);
        countApply  = countPend_q && (countWait_q == 2'h1);
        periodApply = periodPend_q && (periodWait_q == 2'h1);

        postCount_d  = postCount_q;
        postPeriod_d = postPeriod_q;
        countPend_d  = countPend_q;
        periodPend_d = periodPend_q;
        countWait_d  = countPend_q ? countWait_q - 2'h1 : 2'h0;
        periodWait_d = periodPend_q ? periodWait_q - 2'h1 : 2'h0;
        if (countApply) begin
            countPend_d = 1'b0;
        end
        if (periodApply) begin
            periodPend_d = 1'b0;
        end
        if (countWrite && asyncMode && !syncCounter) begin
            if (!(ctrl_q.asyncWriteBlock && (countPend_q || periodPend_q))) begin
                postCount_d = regWdata;
                countPend_d = 1'b1;
                countWait_d = interval_timer_pkg::POST_WRITE_CYCLES;
            end
        end
        if (periodWrite && asyncMode) begin
            postPeriod_d = regWdata;
            periodPend_d = 1'b1;
            periodWait_d = interval_timer_pkg::POST_WRITE_CYCLES;
        end
    end

    // counter and period
    always_comb begin
        count_d  = count_q;
        period_d = period_q;
        event_d  = 1'b0;
        if (countTick) begin
            if (match) begin
                count_d = interval_timer_pkg::COUNT_RESET;
                event_d = 1'b1;
            end else begin
                count_d = count_q + 16'h0001;
            end
        end
        if (countApply) begin
            count_d = postCount_q;
        end else if (countWrite && !asyncMode && !(syncCounter && ctrl_q.timerOn)) begin
            count_d = regWdata;
        end
        if (periodApply) begin
            period_d = postPeriod_q;
        end else if (periodWrite && !asyncMode) begin
            period_d = regWdata;
        end
    end

    // control, interrupt and read data
    always_comb begin
        ctrl_d      = ctrl_q;
        irqMask_d   = irqMask_q;
        irqStatus_d = irqStatus_q;
        rdata_d     = 16'h0000;
        if (regWrite) begin
            unique case (regAddr)
                interval_timer_pkg::ADDR_CONTROL: begin
                    ctrl_d.timerOn             = regWdata[interval_timer_pkg::BIT_TIMER_ON];
                    ctrl_d.idleStop            = regWdata[interval_timer_pkg::BIT_IDLE_STOP];
                    ctrl_d.asyncWriteBlock     = regWdata[interval_timer_pkg::BIT_WRITE_BLOCK];
                    ctrl_d.extendedClockSelect =
                        regWdata[interval_timer_pkg::BIT_EXT_SEL_HI:
                                 interval_timer_pkg::BIT_EXT_SEL_LO];
                    ctrl_d.gatedAccumulate     = regWdata[interval_timer_pkg::BIT_GATED];
                    ctrl_d.prescaleSelect      =
                        regWdata[interval_timer_pkg::BIT_PRESCALE_HI:
                                 interval_timer_pkg::BIT_PRESCALE_LO];
                    ctrl_d.externalInputSync   = regWdata[interval_timer_pkg::BIT_INPUT_SYNC];
                    ctrl_d.clockSourceSelect   = regWdata[interval_timer_pkg::BIT_CLOCK_SOURCE];
                end
                interval_timer_pkg::ADDR_IRQ_STATUS: begin
                    if (regWdata[interval_timer_pkg::BIT_IRQ_PERIOD]) begin
                        irqStatus_d = 1'b0;
                    end
                end
                interval_timer_pkg::ADDR_IRQ_MASK: begin
                    irqMask_d = regWdata[interval_timer_pkg::BIT_IRQ_PERIOD];
                end
                default: begin
                end
            endcase
        end
        // a new event beats a simultaneous clear
        if (event_d) begin
            irqStatus_d = 1'b1;
        end
        irqOut_d = irqStatus_d && irqMask_d;
        if (regRead) begin
            unique case (regAddr)
                interval_timer_pkg::ADDR_CONTROL:
                    rdata_d = packControl(ctrl_q, countPend_q, periodPend_q);
                interval_timer_pkg::ADDR_COUNT:
                    rdata_d = count_q;
                interval_timer_pkg::ADDR_PERIOD:
                    rdata_d = period_q;
                interval_timer_pkg::ADDR_IRQ_STATUS:
                    rdata_d[interval_timer_pkg::BIT_IRQ_PERIOD] = irqStatus_q;
                interval_timer_pkg::ADDR_IRQ_MASK:
                    rdata_d[interval_timer_pkg::BIT_IRQ_PERIOD] = irqMask_q;
                default:
                    rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_q       <= '0;
            count_q      <= interval_timer_pkg::COUNT_RESET;
            period_q     <= interval_timer_pkg::PERIOD_RESET;
            postCount_q  <= interval_timer_pkg::COUNT_RESET;
            postPeriod_q <= interval_timer_pkg::PERIOD_RESET;
            countPend_q  <= 1'b0;
            periodPend_q <= 1'b0;
            countWait_q  <= 2'h0;
            periodWait_q <= 2'h0;
            irqStatus_q  <= 1'b0;
            irqMask_q    <= 1'b0;
            rdata_q      <= 16'h0000;
            event_q      <= 1'b0;
            irqOut_q     <= 1'b0;
            srcPrev_q    <= 1'b0;
            syncA_q      <= 1'b0;
            syncB_q      <= 1'b0;
        end else begin
            ctrl_q       <= ctrl_d;
            count_q      <= count_d;
            period_q     <= period_d;
            postCount_q  <= postCount_d;
            postPeriod_q <= postPeriod_d;
            countPend_q  <= countPend_d;
            periodPend_q <= periodPend_d;
            countWait_q  <= countWait_d;
            periodWait_q <= periodWait_d;
            irqStatus_q  <= irqStatus_d;
            irqMask_q    <= irqMask_d;
            rdata_q      <= rdata_d;
            event_q      <= event_d;
            irqOut_q     <= irqOut_d;
            srcPrev_q    <= srcLevel;
            syncA_q      <= preTick;
            syncB_q      <= syncA_q;
        end
    end

    assign regRdata    = rdata_q;
    assign periodEvent = event_q;
    assign irq         = irqOut_q;

endmodule

// file: dv/interval_timer_properties.sv
`timescale 1ns/1ps
module interval_timer_properties (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // register port
    input  wire logic [2:0]  regAddr,
    input  wire logic [15:0] regWdata,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire logic [15:0] regRdata,
    // events
    input  wire logic        periodEvent,
    input  wire logic        irq
);
    logic [15:0] ctrlShadow_q;
    logic [15:0] ctrlShadow_d;
    logic        maskShadow_q;
    logic        maskShadow_d;
    logic [3:0]  offCount_q;
    logic [3:0]  offCount_d;
    // posting follows the source and sync bits alone, whether or not the timer runs
    wire asyncOn  = ctrlShadow_q[1] && !ctrlShadow_q[2];
    wire wrCount  = regWrite && regAddr == interval_timer_pkg::ADDR_COUNT;
    wire wrPeriod = regWrite && regAddr == interval_timer_pkg::ADDR_PERIOD;
    wire rdCtrl   = regRead && regAddr == interval_timer_pkg::ADDR_CONTROL;
    wire rdPeriod = regRead && regAddr == interval_timer_pkg::ADDR_PERIOD;

    always_comb begin
        ctrlShadow_d = ctrlShadow_q;
        maskShadow_d = maskShadow_q;
        offCount_d   = offCount_q;
        if (regWrite && regAddr == interval_timer_pkg::ADDR_CONTROL) ctrlShadow_d = regWdata;
        if (regWrite && regAddr == interval_timer_pkg::ADDR_IRQ_MASK) maskShadow_d = regWdata[0];
        if (ctrlShadow_q[15]) offCount_d = 4'h0;
        else if (offCount_q != 4'hF) offCount_d = offCount_q + 4'h1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrlShadow_q <= 16'h0000;
            maskShadow_q <= 1'b0;
            offCount_q   <= 4'h0;
        end else begin
            ctrlShadow_q <= ctrlShadow_d;
            maskShadow_q <= maskShadow_d;
            offCount_q   <= offCount_d;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_IDLE_RDATA_ZERO: assert property (!$past(regRead) |-> regRdata == 16'h0000)
        else $error("read data not zero outside read answer");
    AST_UNMAPPED_ZERO: assert property ($past(regRead) && $past(regAddr) > 3'h4 |->
        regRdata == 16'h0000)
        else $error("unmapped read not zero");
    AST_CTRL_UNUSED_ZERO: assert property ($past(rdCtrl) |-> regRdata[14] == 1'b0 &&
        regRdata[6] == 1'b0 && regRdata[3] == 1'b0 && regRdata[0] == 1'b0)
        else $error("unused control bits not zero");
    AST_PERIOD_READBACK: assert property (wrPeriod && !asyncOn ##1 rdPeriod |=>
        regRdata == $past(regWdata, 2))
        else $error("period readback wrong");
    AST_PENDING_SET: assert property (wrCount && asyncOn && !ctrlShadow_q[12]
        ##1 rdCtrl |=> regRdata[11])
        else $error("count pending flag not set");
    // the posted value lands on the third edge after the write, so the flag reads low a cycle later
    AST_PENDING_CLEAR: assert property (wrCount && asyncOn ##1 !regWrite [*3]
        ##1 rdCtrl |=> !regRdata[11])
        else $error("count pending flag not cleared");
    AST_IRQ_NEEDS_MASK: assert property (irq |-> maskShadow_q)
        else $error("irq high while masked");
    AST_EVENT_RAISES_IRQ: assert property (periodEvent && maskShadow_q |-> ##[1:2] irq)
        else $error("unmasked event gave no irq");
    AST_STOPPED_NO_EVENT: assert property (offCount_q == 4'hF |-> !periodEvent)
        else $error("event while timer off");

    COV_EVENT: cover property (periodEvent);
    COV_IRQ_FALL: cover property ($fell(irq));
    COV_PENDING: cover property (wrCount && asyncOn);
endmodule

bind interval_timer interval_timer_properties i_props (
    .clk        (clk),
    .rst_n      (rst_n),
    .regAddr    (regAddr),
    .regWdata   (regWdata),
    .regWrite   (regWrite),
    .regRead    (regRead),
    .regRdata   (regRdata),
    .periodEvent(periodEvent),
    .irq        (irq)
);

// file: dv/count_source_model.sv
`timescale 1ns/1ps
module count_source_model #(
    parameter int HALF = 3
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // control
    input  wire logic       run,
    input  wire logic [1:0] sel,
    // source levels
    output logic            pinLevel,
    output logic            instrLevel,
    output logic            oscLevel,
    output logic            fastRcLevel,
    output int              risingEdges
);
    logic level = 1'b0;
    int   phase = 0;
    // unselected lines stay low so a wrong route shows as a count error
    assign pinLevel    = level && sel == interval_timer_pkg::EXT_PIN;
    assign instrLevel  = level && sel == interval_timer_pkg::EXT_INSTR;
    assign oscLevel    = level && sel == interval_timer_pkg::EXT_OSC;
    assign fastRcLevel = level && sel == interval_timer_pkg::EXT_FAST_RC;

    // clock stands still low outside bursts
    always @(posedge clk) begin
        if (!rst_n) risingEdges <= 0;
        else if (run && phase == HALF - 1 && !level) risingEdges <= risingEdges + 1;
        if (!rst_n || !run) begin
            level <= 1'b0;
            phase <= 0;
        end else if (phase == HALF - 1) begin
            level <= !level;
            phase <= 0;
        end else begin
            phase <= phase + 1;
        end
    end
endmodule

// file: dv/tb.sv
`timescale 1ns/1ps
module tb;
    typedef struct packed {
        logic [15:0] lo;
        logic [15:0] hi;
        logic [15:0] mask;
    } note_type;
    localparam logic [15:0] ON = 16'h8000;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [2:0]  regAddr = 3'h0;
    logic [15:0] regWdata = 16'h0000;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic [15:0] regRdata;
    logic        gateIn = 1'b0;
    logic        idleMode = 1'b0;
    logic        sleepMode = 1'b0;
    logic        run = 1'b0;
    logic        readSeen = 1'b0;
    logic [1:0]  sel = 2'h0;
    logic        pin, instr, osc, fast_rc_oscillator, periodEvent, irq;
    logic [31:0] rnd = 32'h6812;
    logic [15:0] a, b, per;
    int          errors = 0;
    int          checked = 0;
    int          cyc = 0;
    int          edges, base, t0, t1;
    int          ratio[4] = '{1, 8, 64, 256};
    note_type    notes[$];

    always #25 clk = !clk;
    always @(posedge clk) cyc <= cyc + 1;

    interval_timer i_dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
        .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .externalCountInput(pin), .instrClockIn(instr), .oscClockIn(osc), .fastRcClockIn(fast_rc_oscillator),
        .gateIn(gateIn), .idleMode(idleMode), .sleepMode(sleepMode),
        .periodEvent(periodEvent), .irq(irq));
    count_source_model i_src (.clk(clk), .rst_n(rst_n), .run(run), .sel(sel), .pinLevel(pin),
        .instrLevel(instr), .oscLevel(osc), .fastRcLevel(fast_rc_oscillator), .risingEdges(edges));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic fail(input logic [31:0] got, input logic [31:0] want);
        errors++;
        $display("unexpected value at %0t: got %h want %h", $time, got, want);
    endtask
    task automatic cmpRead(input logic [15:0] got, input note_type n);
        checked++;
        if ((((got & n.mask) >= n.lo) && ((got & n.mask) <= n.hi)) !== 1'b1) fail(got, n.lo);
    endtask
    task automatic cmpNum(input logic [31:0] got, input logic [31:0] want);
        checked++;
        if (got !== want) fail(got, want);
    endtask

    // read answers are checked one cycle after the strobe, oldest note first
    always @(posedge clk) begin
        readSeen <= regRead;
        if (readSeen) cmpRead(regRdata, notes.pop_front());
    end

    task automatic wr(input logic [2:0] ad, input logic [15:0] d);
        regAddr <= ad;
        regWdata <= d;
        regWrite <= 1'b1;
        regRead <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [2:0] ad, input logic [15:0] lo, hi, mask);
        notes.push_back('{lo, hi, mask});
        regAddr <= ad;
        regRead <= 1'b1;
        regWrite <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdv(input logic [2:0] ad, input logic [15:0] v);
        rd(ad, v, v, 16'hFFFF);
    endtask
    task automatic idl(input int n);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        repeat (n) @(posedge clk);
    endtask
    task automatic waitEv(output int t);
        int n;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (periodEvent !== 1'b1 && n < 3000);
        if (n >= 3000) fail(0, 1);
        t = cyc;
        @(posedge clk);
    endtask
    task automatic burst(input int n);
        base = edges;
        run <= 1'b1;
        idl(n);
        run <= 1'b0;
        idl(8);
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        conclude();
    end

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdv(3'h0, 16'h0000);
        rdv(3'h1, 16'h0000);
        rdv(3'h2, 16'hFFFF);
        rdv(3'h4, 16'h0000);
        rdv(3'h5, 16'h0000);
        rdv(3'h7, 16'h0000);
        for (int p = 0; p < 4; p++) begin
            rnd = lfsr(rnd);
            per = {14'h0000, rnd[1:0]} + 16'h0001;
            wr(3'h0, 16'h0000);
            wr(3'h1, 16'h0000);
            wr(3'h2, per);
            rdv(3'h2, per);
            wr(3'h0, ON | (16'(p) << 4));
            idl(1);
            waitEv(t0);
            waitEv(t1);
            cmpNum(t1 - t0, ratio[p] * (per + 1));
        end
        wr(3'h4, 16'h0001);
        idl(1);
        waitEv(t0);
        idl(3);
        @(negedge clk);
        cmpNum(irq, 1);
        @(posedge clk);
        wr(3'h0, 16'h0000);
        idl(4);
        wr(3'h3, 16'h0001);
        idl(3);
        @(negedge clk);
        cmpNum(irq, 0);
        @(posedge clk);
        rdv(3'h3, 16'h0000);
        rnd = lfsr(rnd);
        wr(3'h2, 16'hFFFF);
        wr(3'h1, rnd[15:0]);
        idl(20);
        rdv(3'h1, rnd[15:0]);
        wr(3'h1, 16'h0000);
        wr(3'h0, ON | 16'h0080);
        idl(10);
        rdv(3'h1, 16'h0000);
        gateIn <= 1'b1;
        idl(10);
        gateIn <= 1'b0;
        idl(4);
        rd(3'h1, 16'd8, 16'd12, 16'hFFFF);
        wr(3'h0, 16'h0000);
        wr(3'h1, 16'h0000);
        idleMode <= 1'b1;
        wr(3'h0, ON | 16'h2000);
        idl(10);
        rdv(3'h1, 16'h0000);
        wr(3'h0, ON);
        idl(10);
        rd(3'h1, 16'd5, 16'd15, 16'hFFFF);
        idleMode <= 1'b0;
        sleepMode <= 1'b1;
        idl(2);
        wr(3'h1, 16'h0000);
        idl(10);
        rdv(3'h1, 16'h0000);
        sleepMode <= 1'b0;
        for (int s = 0; s < 4; s++) begin
            sel <= 2'(s);
            wr(3'h0, 16'h0000);
            wr(3'h1, 16'h0000);
            // software keeps the synchronised mode whenever the count feeds capture/compare
            wr(3'h0, ON | (16'(s) << 8) | 16'h0086);
            burst(40);
            rdv(3'h1, 16'(edges - base));
        end
        rnd = lfsr(rnd);
        wr(3'h1, rnd[15:0] | 16'h8000);
        idl(4);
        rdv(3'h1, 16'(edges - base));
        sel <= 2'h0;
        wr(3'h0, 16'h0000);
        wr(3'h1, 16'h0000);
        wr(3'h0, ON | 16'h1002);
        sleepMode <= 1'b1;
        burst(40);
        rdv(3'h1, 16'(edges - base));
        sleepMode <= 1'b0;
        rnd = lfsr(rnd);
        a = rnd[15:0];
        b = ~a;
        wr(3'h1, a);
        wr(3'h1, b);
        idl(6);
        rdv(3'h1, a);
        wr(3'h0, ON | 16'h0002);
        wr(3'h1, a);
        // the flag stands for three read cycles and is low on the fourth
        rd(3'h0, 16'h0800, 16'h0800, 16'h0800);
        rdv(3'h0, 16'h8802);
        rd(3'h0, 16'h0800, 16'h0800, 16'h0800);
        rd(3'h0, 16'h0000, 16'h0000, 16'h0800);
        wr(3'h1, a);
        wr(3'h1, b);
        wr(3'h2, a);
        rd(3'h0, 16'h0400, 16'h0400, 16'h0400);
        idl(6);
        rdv(3'h1, b);
        rdv(3'h2, a);
        idl(4);
        conclude();
    end
endmodule
